// [rtl/dram_ctrl.sv]
`timescale 1ns/10ps
`include "dram_mux_cfg.svh"

// How it works
// - Processor flags refresh and row each fetch
// - Processor advances refresh row after each refresh
// - 64 rows for 4K, 128 for 16K
// - Split address into equal row/column groups
// - Row group from lowest bits, row strobe
// - Column group from next bits, column strobe
// - Refresh routes row side of multiplexer
// - Processor drives row address with request
// - Refresh strobes row only, within 2 ms
// - Cycling a row refreshes all its cells
// - Processor fetch gap at most 19 states
// - No own refresh counter; address multiplexer is built in
// - Select pin: chip select or bit six
// - Stretch row strobe precharge after release
// - Cycle type from column and write strobes
module dram_ctrl (
  input  wire logic    clk,         // 250 MHz clock
  input  wire logic    sys_rst,     // Async reset, active high
  input  wire logic    big_dev,     // 1 for 16K parts, 0 for 4K
  input  wire logic    chip_en,     // Chip select for 4K parts
  output logic         busy,        // Memory cycle in progress
  output logic         in_refresh,  // Refresh cycle in progress
  dram_bus_if.ctrl     bus          // Processor and DRAM pins
);
  typedef struct packed {
    dram_mux_pkg::ctl_state_t st;
    logic [`CYC_W-1:0]        cnt;
    logic                     req_s1;
    logic                     req_s2;
    logic                     refresh_indicator_n_s1;
    logic                     refresh_indicator_n_s2;
    logic                     wr_s1;
    logic                     wr_s2;
    logic                     refr;
    logic                     ras_n;
    logic                     cas_n;
    logic                     we_n;
    logic                     col_sel;
    logic                     sel_n;
    logic [`MUX_W-1:0]        mux;
  } ctl_regs_t;

  ctl_regs_t         cur_ff;
  ctl_regs_t         nxt_cur;
  logic [`MUX_W-1:0] grp;

  // ****************************************
  // Address multiplexer
  // ****************************************
  addr_split u_split (
    .addr    (bus.addr),
    .big_dev (big_dev),
    .col_sel (nxt_cur.col_sel),
    .grp     (grp)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  // Pin inputs pass two flops; address is stable before request so not synced
  always_comb begin
    nxt_cur         = cur_ff;
    nxt_cur.req_s1  = ~bus.memory_request_n;
    nxt_cur.req_s2  = cur_ff.req_s1;
    nxt_cur.refresh_indicator_n_s1 = ~bus.refresh_indicator_n;
    nxt_cur.refresh_indicator_n_s2 = cur_ff.refresh_indicator_n_s1;
    nxt_cur.wr_s1   = ~bus.write_n;
    nxt_cur.wr_s2   = cur_ff.wr_s1;
    case (cur_ff.st)
      dram_mux_pkg::ST_IDLE: begin
        nxt_cur.col_sel = 1'b0;
        if (cur_ff.req_s2) begin
          // Refresh uses the processor row address, no local counter
          nxt_cur.refr  = cur_ff.refresh_indicator_n_s2;
          nxt_cur.ras_n = 1'b0;
          nxt_cur.cnt   = `CYC_W'(`RCD_CYC);
          nxt_cur.st    = cur_ff.refresh_indicator_n_s2 ? dram_mux_pkg::ST_REFR
                                         : dram_mux_pkg::ST_ROW;
        end
      end
      dram_mux_pkg::ST_ROW: begin
        // Hold row address past the strobe before switching
        if (cur_ff.cnt == `CYC_W'(1)) begin
          nxt_cur.col_sel = 1'b1;
          nxt_cur.st      = dram_mux_pkg::ST_COL;
        end else begin
          nxt_cur.cnt = cur_ff.cnt - `CYC_W'(1);
        end
      end
      dram_mux_pkg::ST_COL: begin
        nxt_cur.cas_n = 1'b0;
        nxt_cur.st    = dram_mux_pkg::ST_CAS;
      end
      dram_mux_pkg::ST_CAS: begin
        // Write follows the processor strobe: delayed write, one cycle after the column strobe
        nxt_cur.we_n = ~cur_ff.wr_s2;
        if (!cur_ff.req_s2) begin
          nxt_cur.ras_n   = 1'b1;
          nxt_cur.cas_n   = 1'b1;
          nxt_cur.we_n    = 1'b1;
          nxt_cur.col_sel = 1'b0;
          nxt_cur.cnt     = `CYC_W'(`PRECHARGE_CYC);
          nxt_cur.st      = dram_mux_pkg::ST_PRE;
        end
      end
      dram_mux_pkg::ST_REFR: begin
        // Row only; column strobe stays high, mux stays on row side
        nxt_cur.cas_n   = 1'b1;
        nxt_cur.col_sel = 1'b0;
        if (!cur_ff.req_s2) begin
          nxt_cur.ras_n = 1'b1;
          nxt_cur.cnt   = `CYC_W'(`PRECHARGE_CYC);
          nxt_cur.st    = dram_mux_pkg::ST_PRE;
        end
      end
      dram_mux_pkg::ST_PRE: begin
        // Short request gap would violate precharge, so hold row high
        if (cur_ff.cnt == `CYC_W'(1)) begin
          nxt_cur.refr = 1'b0;
          nxt_cur.st   = dram_mux_pkg::ST_IDLE;
        end else begin
          nxt_cur.cnt = cur_ff.cnt - `CYC_W'(1);
        end
      end
      default: begin
        nxt_cur.st    = dram_mux_pkg::ST_IDLE;
        nxt_cur.ras_n = 1'b1;
        nxt_cur.cas_n = 1'b1;
        nxt_cur.we_n  = 1'b1;
      end
    endcase
    nxt_cur.mux = grp;
    // Pin 13 is chip select on 4K parts, address bit six on 16K parts
    nxt_cur.sel_n = big_dev ? grp[`MUX_W-1] : ~chip_en;
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff <= '{st: dram_mux_pkg::ST_IDLE, cnt: '0, req_s1: 1'b0, req_s2: 1'b0,
                  refresh_indicator_n_s1: 1'b0, refresh_indicator_n_s2: 1'b0, wr_s1: 1'b0, wr_s2: 1'b0,
                  refr: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                  col_sel: 1'b0, sel_n: 1'b1, mux: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Outputs straight from flops; busy decoded from the state flops
  assign bus.mux_addr     = cur_ff.mux;
  assign bus.row_strobe_n = cur_ff.ras_n;
  assign bus.col_strobe_n = cur_ff.cas_n;
  assign bus.mem_write_n  = cur_ff.we_n;
  assign bus.select_n     = cur_ff.sel_n;
  assign busy             = (cur_ff.st != dram_mux_pkg::ST_IDLE);
  assign in_refresh       = cur_ff.refr;
endmodule : dram_ctrl

// [rtl/dram_mux_cfg.svh]
`ifndef DRAM_MUX_CFG_SVH
`define DRAM_MUX_CFG_SVH

// ****************************************
// Address layout
// ****************************************
`define ADDR_W        16
`define MUX_W         7
`define ROW_LO        0
`define COL_LO_4K     6
`define COL_LO_16K    7
`define ROW_BITS_4K   6
`define ROW_BITS_16K  7
`define ROWS_4K       8'h40
`define ROWS_16K      8'h80

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS   4
`define MIN_PRECHARGE_NS 105
`define PRECHARGE_CYC   ((`MIN_PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_MS      2
`define FETCH_GAP_T     19
`define RCD_CYC         2
`define CYC_W           6

`endif

// [rtl/dram_mux_pkg.sv]
package dram_mux_pkg;
  // Controller sequencing states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ROW   = 6'h02,
    ST_COL   = 6'h04,
    ST_CAS   = 6'h08,
    ST_REFR  = 6'h10,
    ST_PRE   = 6'h20
  } ctl_state_t;

  // Processor request source states
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_REQ  = 4'h2,
    HS_GAP  = 4'h4,
    HS_WAIT = 4'h8
  } host_state_t;
endpackage : dram_mux_pkg

// [rtl/dram_bus_if.sv]
`timescale 1ns/10ps
`include "dram_mux_cfg.svh"

// Processor bus side plus the shared DRAM pins
interface dram_bus_if;
  logic [`ADDR_W-1:0] addr;
  logic               memory_request_n;
  logic               refresh_indicator_n;
  logic               write_n;
  logic [`MUX_W-1:0]  mux_addr;
  logic               row_strobe_n;
  logic               col_strobe_n;
  logic               mem_write_n;
  logic               select_n;

  modport ctrl (
    input  addr, memory_request_n, refresh_indicator_n, write_n,
    output mux_addr, row_strobe_n, col_strobe_n, mem_write_n, select_n
  );
  modport cpu (
    output addr, memory_request_n, refresh_indicator_n, write_n,
    input  mux_addr, row_strobe_n, col_strobe_n, mem_write_n, select_n
  );
endinterface : dram_bus_if

// [rtl/addr_split.sv]
`timescale 1ns/10ps
`include "dram_mux_cfg.svh"

// ****************************************
// Row/column address selector
// ****************************************
module addr_split (
  input  wire logic [`ADDR_W-1:0] addr,        // Processor address
  input  wire logic               big_dev,     // 1 selects 16K parts
  input  wire logic               col_sel,     // 1 drives column group
  output logic      [`MUX_W-1:0]  grp          // Selected group
);
  logic [`MUX_W-1:0] row_g;
  logic [`MUX_W-1:0] col_g;

  // Group extraction per device size
  always_comb begin
    row_g = addr[`ROW_LO +: `MUX_W];
    if (big_dev) begin
      col_g = addr[`COL_LO_16K +: `MUX_W];
    end else begin
      col_g = {1'b0, addr[`COL_LO_4K +: `ROW_BITS_4K]};
      row_g[`MUX_W-1] = 1'b0;
    end
    grp = col_sel ? col_g : row_g;
  end
endmodule : addr_split

// [rtl/cpu_end.sv]
`timescale 1ns/10ps
`include "dram_mux_cfg.svh"

// ****************************************
// Processor-side request source
// ****************************************
module cpu_end (
  input  wire logic               clk,        // 250 MHz clock
  input  wire logic               sys_rst,    // Async reset, active high
  input  wire logic               big_dev,    // 1 for 16K parts
  input  wire logic               acc_req,    // Start a data access, pulse
  input  wire logic               acc_wr,     // Access is a write
  input  wire logic [`ADDR_W-1:0] acc_addr,   // Access address
  input  wire logic [`CYC_W-1:0]  hold_cyc,   // Request low time, cycles
  output logic                    acc_ready,  // Idle after a refresh, may take acc_req
  output logic [`CYC_W-1:0]       gap_cnt,    // Cycles since last refresh
  dram_bus_if.cpu                 bus         // Processor and DRAM pins
);
  typedef struct packed {
    dram_mux_pkg::host_state_t st;
    logic [`CYC_W-1:0]         cnt;
    logic [`CYC_W-1:0]         gap;
    logic [7:0]                row;
    logic                      refresh_indicator_n_next;
    logic [`ADDR_W-1:0]        addr;
    logic                      memory_request_n_n;
    logic                      refresh_indicator_n_n;
    logic                      wr_n;
  } cpu_regs_t;

  cpu_regs_t cur_ff;
  cpu_regs_t nxt_cur;

  // Alternate data access and refresh so no fetch gap grows unbounded
  always_comb begin
    nxt_cur     = cur_ff;
    nxt_cur.gap = (cur_ff.gap == {`CYC_W{1'b1}}) ? cur_ff.gap : cur_ff.gap + `CYC_W'(1);
    case (cur_ff.st)
      dram_mux_pkg::HS_IDLE: begin
        if (cur_ff.refresh_indicator_n_next || !acc_req) begin
          // Refresh row on low bits with indicator
          nxt_cur.addr   = {8'h00, cur_ff.row};
          nxt_cur.refresh_indicator_n_n = 1'b0;
          nxt_cur.wr_n   = 1'b1;
          nxt_cur.gap    = '0;
        end else begin
          nxt_cur.addr   = acc_addr;
          nxt_cur.refresh_indicator_n_n = 1'b1;
          nxt_cur.wr_n   = ~acc_wr;
        end
        nxt_cur.memory_request_n_n = 1'b0;
        nxt_cur.cnt    = hold_cyc;
        nxt_cur.st     = dram_mux_pkg::HS_REQ;
      end
      dram_mux_pkg::HS_REQ: begin
        if (cur_ff.cnt == '0) begin
          nxt_cur.memory_request_n_n = 1'b1;
          nxt_cur.wr_n   = 1'b1;
          nxt_cur.st     = dram_mux_pkg::HS_GAP;
          if (!cur_ff.refresh_indicator_n_n) begin
            // Next row, wrapping at 64 or 128 rows
            nxt_cur.row = (cur_ff.row + 8'h01) &
                          (big_dev ? (`ROWS_16K - 8'h01) : (`ROWS_4K - 8'h01));
          end
          nxt_cur.refresh_indicator_n_next = cur_ff.refresh_indicator_n_n;
        end else begin
          nxt_cur.cnt = cur_ff.cnt - `CYC_W'(1);
        end
      end
      dram_mux_pkg::HS_GAP: begin
        nxt_cur.refresh_indicator_n_n = 1'b1;
        nxt_cur.cnt    = `CYC_W'(`PRECHARGE_CYC + `RCD_CYC + 4);
        nxt_cur.st     = dram_mux_pkg::HS_WAIT;
      end
      dram_mux_pkg::HS_WAIT: begin
        // Wait for controller precharge plus sync latency
        if (cur_ff.cnt == '0) begin
          nxt_cur.st = dram_mux_pkg::HS_IDLE;
        end else begin
          nxt_cur.cnt = cur_ff.cnt - `CYC_W'(1);
        end
      end
      default: begin
        nxt_cur.st     = dram_mux_pkg::HS_WAIT;
        nxt_cur.memory_request_n_n = 1'b1;
        nxt_cur.refresh_indicator_n_n = 1'b1;
        nxt_cur.wr_n   = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff <= '{st: dram_mux_pkg::HS_WAIT, cnt: '0, gap: '0, row: 8'h00,
                  refresh_indicator_n_next: 1'b1, addr: '0, memory_request_n_n: 1'b1, refresh_indicator_n_n: 1'b1,
                  wr_n: 1'b1};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign bus.addr                = cur_ff.addr;
  assign bus.memory_request_n    = cur_ff.memory_request_n_n;
  assign bus.refresh_indicator_n = cur_ff.refresh_indicator_n_n;
  assign bus.write_n             = cur_ff.wr_n;
  assign acc_ready = (cur_ff.st == dram_mux_pkg::HS_IDLE) && !cur_ff.refresh_indicator_n_next;
  assign gap_cnt   = cur_ff.gap;
endmodule : cpu_end

// [tb/dram_mux_asserts.sv]
`timescale 1ns/10ps
`include "dram_mux_cfg.svh"

// ****************************************
// Interface checker
// ****************************************
module dram_mux_asserts (
  input wire logic               clk,                  // Clock
  input wire logic               sys_rst,              // Reset
  input wire logic               big_dev,              // 16K parts
  input wire logic               chip_en,              // 4K select
  input wire logic [`ADDR_W-1:0] addr,                 // Processor address
  input wire logic               memory_request_n,     // Request
  input wire logic               refresh_indicator_n,  // Refresh flag
  input wire logic [`MUX_W-1:0]  mux_addr,             // Shared pins
  input wire logic               row_strobe_n,         // Row strobe
  input wire logic               col_strobe_n,         // Column strobe
  input wire logic               mem_write_n,          // Write strobe
  input wire logic               select_n              // Select pin
);
  logic [6:0] m;
  logic [6:0] colv;
  logic [6:0] hi_cnt;
  logic       row_d;
  logic       rfr;

  // Group masks; 4K parts leave pin six out of the groups
  assign m    = big_dev ? 7'h7F : 7'h3F;
  assign colv = big_dev ? addr[13:7] : {1'b0, addr[11:6]};

  // High-time counter saturates so reset never looks like a short precharge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      row_d  <= 1'b1;
      hi_cnt <= 7'h7F;
      rfr    <= 1'b0;
    end else begin
      row_d  <= row_strobe_n;
      hi_cnt <= !row_strobe_n ? 7'h00 : (hi_cnt == 7'h7F ? hi_cnt : hi_cnt + 7'h01);
      if (row_d && !row_strobe_n) rfr <= !refresh_indicator_n;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_row_src;
    $fell(row_strobe_n) |-> !$past(memory_request_n, 2) && !$past(memory_request_n, 3);
  endproperty
  a_row_src: assert property (p_row_src) else $error("row strobe without request");
  property p_row_grp;
    $fell(row_strobe_n) |-> (mux_addr & m) == (addr[6:0] & m);
  endproperty
  a_row_grp: assert property (p_row_grp) else $error("row group wrong");
  property p_col_grp;
    $fell(col_strobe_n) |-> (mux_addr & m) == colv;
  endproperty
  a_col_grp: assert property (p_col_grp) else $error("column group wrong");
  property p_col_order;
    $fell(col_strobe_n) |-> !row_strobe_n && !$past(row_strobe_n, 3) && $stable(mux_addr);
  endproperty
  a_col_order: assert property (p_col_order) else $error("column before switch");
  property p_refr_ras;
    rfr && !row_strobe_n |-> col_strobe_n;
  endproperty
  a_refr_ras: assert property (p_refr_ras) else $error("column strobe in refresh");
  property p_precharge;
    $fell(row_strobe_n) |-> hi_cnt >= `PRECHARGE_CYC;
  endproperty
  a_precharge: assert property (p_precharge) else $error("row precharge short");
  property p_select;
    $fell(row_strobe_n) && $stable(chip_en) && $past(chip_en, 2) == chip_en
      |-> select_n == (big_dev ? addr[6] : !chip_en);
  endproperty
  a_select: assert property (p_select) else $error("select pin wrong");
  property p_write;
    !mem_write_n |-> !col_strobe_n && !row_strobe_n;
  endproperty
  a_write: assert property (p_write) else $error("write strobe outside column");
endmodule : dram_mux_asserts

// [tb/tb.sv]
`timescale 1ns/10ps
`include "dram_mux_cfg.svh"

module tb;
  logic                clk, sys_rst, big_dev, chip_en, acc_req, acc_wr;
  logic [`ADDR_W-1:0]  acc_addr, cur_a;
  logic [`CYC_W-1:0]   hold_cyc, gap;
  logic                acc_ready, busy, in_refresh, cur_wr;
  logic                row_q, col_q, wlow, ew, acc;
  logic [`MUX_W-1:0]   exp_row, msk, ec;
  logic [15:0]         corner [4] = '{16'h0000, 16'hFFFF, 16'h3F80, 16'h0FC0};
  int                  err_count, checks, refs, cyc;

  dram_bus_if ifc ();
  dram_ctrl i_dram_ctrl (.clk(clk), .sys_rst(sys_rst), .big_dev(big_dev),
    .chip_en(chip_en), .busy(busy), .in_refresh(in_refresh), .bus(ifc.ctrl));
  cpu_end i_cpu_end (.clk(clk), .sys_rst(sys_rst), .big_dev(big_dev), .acc_req(acc_req),
    .acc_wr(acc_wr), .acc_addr(acc_addr), .hold_cyc(hold_cyc), .acc_ready(acc_ready),
    .gap_cnt(gap), .bus(ifc.cpu));
  dram_mux_asserts i_dram_mux_asserts (.clk(clk), .sys_rst(sys_rst), .big_dev(big_dev),
    .chip_en(chip_en), .addr(ifc.addr), .memory_request_n(ifc.memory_request_n),
    .refresh_indicator_n(ifc.refresh_indicator_n), .mux_addr(ifc.mux_addr),
    .row_strobe_n(ifc.row_strobe_n), .col_strobe_n(ifc.col_strobe_n),
    .mem_write_n(ifc.mem_write_n), .select_n(ifc.select_n));

  assign msk = big_dev ? 7'h7F : 7'h3F;

  // ****************************************
  // Expectations and compares
  // ****************************************
  function automatic logic [6:0] col_of(input logic [15:0] a, input logic b);
    col_of = b ? a[13:7] : {1'b0, a[11:6]};
  endfunction : col_of

  task automatic chk_grp(input string n, input logic [6:0] e, input logic [6:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk_grp

  task automatic chk_bit(input string n, input logic e, input logic s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s exp %b got %b", n, e, s);
    end
  endtask : chk_bit

  task automatic tally_and_finish;
    if (err_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // One access; waits for the source to be idle so the request is honoured
  task automatic access(input logic [15:0] a, input logic w);
    int n;
    for (n = 0; n < 400 && acc_ready !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    acc_req  = 1'b1;
    acc_addr = a;
    acc_wr   = w;
    cur_a    = a;
    cur_wr   = w;
    hold_cyc = 6'(8 + $urandom % 33);
    chip_en  = 1'($urandom);
    @(posedge clk);
    #1 acc_req = 1'b0;
  endtask : access

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************
  // Bus monitor and hang guard
  // ****************************************
  always @(posedge clk) begin
    cyc++;
    if (cyc > 60000) begin
      err_count++;
      tally_and_finish();
    end
    if (sys_rst) begin
      exp_row = 7'h00;
      refs = 0;
      row_q = 1'b1;
      col_q = 1'b1;
      acc = 1'b0;
    end else begin
      if (row_q && !ifc.row_strobe_n) begin
        chk_bit("in_refresh", !ifc.refresh_indicator_n, in_refresh);
        chk_bit("busy", 1'b1, busy);
        if (!ifc.refresh_indicator_n) begin
          // Gap counter cleared when the refresh request went out, three edges back
          chk_grp("gap_cnt", 7'h03, {1'b0, gap});
          chk_grp("refresh row", exp_row, ifc.mux_addr & msk);
          exp_row = (exp_row + 7'h01) & msk;
          refs++;
        end else begin
          chk_grp("row group", cur_a[6:0] & msk, ifc.mux_addr & msk);
          ec = col_of(cur_a, big_dev) & msk;
          ew = cur_wr;
          acc = 1'b1;
        end
        wlow = 1'b0;
      end
      if (col_q && !ifc.col_strobe_n) chk_grp("col group", ec, ifc.mux_addr & msk);
      if (!ifc.mem_write_n) wlow = 1'b1;
      if (!row_q && ifc.row_strobe_n && acc) begin
        chk_bit("write strobe", ew, wlow);
        acc = 1'b0;
      end
      row_q = ifc.row_strobe_n;
      col_q = ifc.col_strobe_n;
    end
  end

  // ****************************************
  // Main sequence: 4K then 16K, reset between
  // ****************************************
  initial begin
    int n;
    logic [15:0] a;
    sys_rst = 1'b1;
    big_dev = 1'b0;
    chip_en = 1'b1;
    acc_req = 1'b0;
    acc_wr = 1'b0;
    acc_addr = 16'h0000;
    hold_cyc = 6'h08;
    cur_a = 16'h0000;
    cur_wr = 1'b0;
    void'($urandom(32'hCFEB));
    for (int ph = 0; ph < 2; ph++) begin
      #1 sys_rst = 1'b1;
      big_dev = (ph == 1);
      repeat (12) @(posedge clk);
      #1 sys_rst = 1'b0;
      for (int k = 0; k < 24; k++) begin
        a = (k < 4) ? corner[k] : 16'($urandom);
        access(a, 1'($urandom));
      end
      // Enough refreshes to see the row counter wrap
      for (n = 0; n < 20000 && refs < 130; n++) @(posedge clk);
      chk_bit("refresh count", 1'b1, refs >= 130);
    end
    tally_and_finish();
  end
endmodule : tb
